//--- dv/core_sleep_clock_gating_tb.sv
/*
 * Testbench joining both ends of the sleep link, one pair per mode.
 * Assumes the design files under rtl/ and the link checker.
 */
`timescale 1ns/1ps

module core_sleep_clock_gating_tb;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic go = 1'h0;
    logic wfi = 1'h0;
    logic elw = 1'h0;
    logic dbg_in = 1'h0;
    logic rd = 1'h0;
    logic gate = 1'h0;
    logic rel = 1'h0;
    logic bus = 1'h0;
    logic ce = 1'h1;
    logic [3:0] dbg = 4'h0;
    logic [31:0] irq_in = 32'h0;
    logic [31:0] en = 32'h0000FFFF;
    logic cg, fg, fen, fst, wk, xen, cg_c, fen_c, xen_c;
    int miscompares = 0;
    int checks = 0;

    // Free running raw clock, 8 ns
    always #4 clk = ~clk;

    csg_if #(.NUM_IRQ(32)) lnk (.clk(clk));
    csg_if #(.NUM_IRQ(32)) lnk_c (.clk(clk));

    // Pair in wait-for-interrupt mode
    csg_sleep_ctrl csg_sleep_ctrl_inst (.clk(clk), .nrst(nrst), .ce(ce),
        .link(lnk), .wfi_exec(wfi), .event_load_wait_insn(elw),
        .irq_local_en(en), .debug_pending(dbg[3]), .debug_mode(dbg[2]),
        .single_step(dbg[1]), .trigger_match(dbg[0]), .clk_gated(cg),
        .fpu_clk_gated(fg), .fpu_clk_en(fen), .fetch_started(fst),
        .wake_seen(wk));
    csg_env_ctrl csg_env_ctrl_inst (.clk(clk), .nrst(nrst), .ce(ce),
        .link(lnk), .fetch_go_in(go), .irq_in(irq_in), .debug_req_in(dbg_in),
        .instr_gnt_in(bus), .instr_rvalid_in(bus), .data_gnt_in(bus),
        .data_rvalid_in(bus), .elw_read_seen(rd), .gate_req(gate),
        .release_req(rel), .ext_clk_en(xen));
    // Pair in cluster mode, fed by the same stimulus
    csg_sleep_ctrl #(.cluster_mode_param(1'h1)) csg_sleep_ctrl_inst2 (
        .clk(clk), .nrst(nrst), .ce(ce), .link(lnk_c), .wfi_exec(wfi),
        .event_load_wait_insn(elw), .irq_local_en(en),
        .debug_pending(dbg[3]), .debug_mode(dbg[2]), .single_step(dbg[1]),
        .trigger_match(dbg[0]), .clk_gated(cg_c), .fpu_clk_gated(),
        .fpu_clk_en(fen_c), .fetch_started(), .wake_seen());
    csg_env_ctrl #(.cluster_mode_param(1'h1)) csg_env_ctrl_inst2 (
        .clk(clk), .nrst(nrst), .ce(ce), .link(lnk_c), .fetch_go_in(go),
        .irq_in(irq_in), .debug_req_in(dbg_in), .instr_gnt_in(bus),
        .instr_rvalid_in(bus), .data_gnt_in(bus), .data_rvalid_in(bus),
        .elw_read_seen(rd), .gate_req(gate), .release_req(rel),
        .ext_clk_en(xen_c));
    csg_link_checker #(.WAKE_MASK(32'h0000FFFF)) csg_link_checker_inst (
        .clk(clk), .nrst(nrst), .fetch_go(lnk.fetch_go),
        .cluster_clk_permit(lnk.cluster_clk_permit),
        .core_sleep(lnk.core_sleep), .irq(lnk.irq),
        .debug_req(lnk.debug_req));

    // Compare one observed value with the expected one
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Let n edges pass, then settle just after the last one
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One cycle of wait-for-interrupt execution
    task automatic pulse_wfi();
        wfi = 1'h1;
        tick(1);
        wfi = 1'h0;
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Samples land 1 ns after the edge, in the high phase of clk
    initial begin
        for (int r = 0; r < 2; r++) begin
            nrst = 1'h0;
            tick(4);
            check(cg, 1'h0);
            check(fen, 1'h0);
            nrst = 1'h1;
            tick(3);
            check(fst, 1'h0);
            check(cg, 1'h0);
            go = 1'h1;
            tick(1);
            go = 1'h0;
            check(fst, 1'h1);
            check(fen, 1'h1);
            tick(1);
            check(cg, 1'h1);
        end
        $display("Test start-up done");
        pulse_wfi();
        check(lnk.core_sleep, 1'h1);
        check(fen, 1'h0);
        check(lnk_c.core_sleep, 1'h0);
        irq_in = 32'h00100000;
        tick(3);
        check(cg, 1'h0);
        check(fg, 1'h0);
        check(xen, 1'h0);
        check(lnk.core_sleep, 1'h1);
        irq_in = 32'h00000008;
        tick(2);
        check(lnk.core_sleep, 1'h0);
        check(wk, 1'h1);
        irq_in = 32'h0;
        tick(1);
        check(wk, 1'h0);
        check(xen, 1'h1);
        check(cg, 1'h1);
        pulse_wfi();
        dbg_in = 1'h1;
        tick(2);
        check(lnk.core_sleep, 1'h0);
        pulse_wfi();
        check(lnk.core_sleep, 1'h0);
        dbg_in = 1'h0;
        tick(2);
        $display("Test wait-for-interrupt done");
        // Each of the four core debug conditions alone, then an enabled line already set
        for (int i = 0; i < 5; i++) begin
            dbg = (i < 4) ? 4'h1 << i : 4'h0;
            irq_in = (i == 4) ? 32'h00000008 : 32'h0;
            tick(2);
            pulse_wfi();
            check(lnk.core_sleep, 1'h0);
            check(wk, 1'h0);
            dbg = 4'h0;
            irq_in = 32'h0;
            tick(2);
        end
        $display("Test refusals done");
        // Clock enable low freezes both ends, even with a wake present
        pulse_wfi();
        ce = 1'h0;
        irq_in = 32'h00000008;
        tick(3);
        check(lnk.core_sleep, 1'h1);
        check(cg, 1'h0);
        ce = 1'h1;
        tick(2);
        check(lnk.core_sleep, 1'h0);
        check(wk, 1'h1);
        irq_in = 32'h0;
        tick(2);
        $display("Test clock enable done");
        elw = 1'h1;
        rd = 1'h1;
        gate = 1'h1;
        tick(1);
        rd = 1'h0;
        check(lnk_c.core_sleep, 1'h1);
        check(cg_c, 1'h1);
        check(fen_c, 1'h0);
        tick(1);
        check(lnk_c.cluster_clk_permit, 1'h0);
        bus = 1'h1;
        tick(2);
        check(lnk_c.data_rvalid, 1'h0);
        check(lnk_c.core_sleep, 1'h1);
        check(cg_c, 1'h0);
        check(xen_c, 1'h1);
        gate = 1'h0;
        rel = 1'h1;
        tick(1);
        rel = 1'h0;
        check(lnk_c.cluster_clk_permit, 1'h1);
        tick(3);
        check(lnk_c.core_sleep, 1'h0);
        check(lnk_c.cluster_clk_permit, 1'h1);
        check(fen_c, 1'h1);
        elw = 1'h0;
        bus = 1'h0;
        $display("Test cluster done");
        conclude();
    end

    // Cuts a hang short; the tests need well under 300 cycles
    initial begin
        #20000;
        miscompares++;
        conclude();
    end
endmodule

//--- dv/csg_link_checker.sv
/*
 * Checker for the sleep link in wait-for-interrupt mode.
 * Assumes a link with cluster mode off and a fixed local wake mask.
 */
`timescale 1ns/1ps

module csg_link_checker #(
    parameter int NUM_IRQ = 32,
    parameter logic [NUM_IRQ-1:0] WAKE_MASK = '1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Link signals
    input wire logic fetch_go,
    input wire logic cluster_clk_permit,
    input wire logic core_sleep,
    input wire logic [NUM_IRQ-1:0] irq,
    input wire logic debug_req
);
    logic go_seen_reg;
    logic go_seen_next;
    logic woken;

    // First fetch go since reset; later ones change nothing
    always_comb go_seen_next = nrst & (go_seen_reg | fetch_go);
    always_ff @(posedge clk) go_seen_reg <= go_seen_next;
    // Only the enabled lines or a debug request may wake, masked lines must not
    assign woken = (|(irq & WAKE_MASK)) | debug_req;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Reset itself is watched, so this one is never disabled
    chk_reset_quiet: assert property (disable iff (1'b0)
        !nrst |=> !core_sleep) else $error("sleep high after reset");
    chk_permit_unused: assert property (!cluster_clk_permit)
        else $error("permit not tied low");
    chk_start_gate: assert property (!go_seen_reg |-> !core_sleep)
        else $error("sleep before first fetch go");
    chk_release_idle: assert property ($rose(nrst) |->
        !core_sleep ##1 !core_sleep) else $error("sleep at release");
    chk_debug_blocks: assert property (debug_req |=> !core_sleep)
        else $error("sleep with debug request");
    chk_wake_bound: assert property (core_sleep && woken |=>
        !core_sleep) else $error("no wake after enabled source");
    chk_no_entry: assert property (!core_sleep && woken |=>
        !core_sleep) else $error("sleep entered with wake present");
    chk_sleep_holds: assert property (core_sleep && !woken |=>
        core_sleep) else $error("sleep ended without cause");
endmodule

//--- rtl/csg_defines.svh
/*
 * Reset values shared by both ends of the core sleep link.
 * Assumes inclusion by bare name from files under rtl/.
 */
`ifndef CSG_DEFINES_SVH
`define CSG_DEFINES_SVH

// Sleep indicator and fetch latch come out of reset cleared
`define CSG_SLEEP_RST 1'h0
`define CSG_FETCH_RST 1'h0
`define CSG_WAKE_RST 1'h0
// Floating-point clock enable is off until the core runs
`define CSG_FPU_EN_RST 1'h0
// Cluster clock permit: low outside cluster mode, high inside it
`define CSG_PERMIT_RST 1'h0
`define CSG_PERMIT_CLUSTER_RST 1'h1
// Event unit arming, masked bus answers, outside clock allowed
`define CSG_ARMED_RST 1'h0
`define CSG_BUS_RST 5'h00
`define CSG_EXT_EN_RST 1'h1
`define CSG_DEFAULT_IRQS 32

`endif

//--- rtl/csg_env_ctrl.sv
/*
 * Logic around the core: start-up, wake sources, bus answers and,
 * in cluster mode, the event unit's clock permit.
 * Assumes all user inputs come from logic on clk.
 */
`timescale 1ns/1ps
`include "csg_defines.svh"

module csg_env_ctrl #(
    parameter int NUM_IRQ = `CSG_DEFAULT_IRQS,
    parameter bit cluster_mode_param = 1'b0
) (
    // Clock, reset, clock enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Link to the sleep controller
    csg_if.host link,
    // System side requests
    input wire logic fetch_go_in,
    input wire logic [NUM_IRQ-1:0] irq_in,
    input wire logic debug_req_in,
    input wire logic instr_gnt_in,
    input wire logic instr_rvalid_in,
    input wire logic data_gnt_in,
    input wire logic data_rvalid_in,
    // Event unit
    input wire logic elw_read_seen,
    input wire logic gate_req,
    input wire logic release_req,
    // External clock gate enable for the core clock
    output logic ext_clk_en
);

    // Refuse configurations the logic cannot serve, at elaboration
    generate
        if (NUM_IRQ < 1) begin : g_bad_irq
            $error("csg_env_ctrl: NUM_IRQ must be at least 1");
        end
    endgenerate

    logic permit_reg;
    logic permit_next;
    logic armed_reg;
    logic armed_next;
    logic [NUM_IRQ-1:0] irq_reg;
    logic [4:0] bus_reg;
    logic [4:0] bus_next;
    logic ext_reg;

    // Permit: tied low outside cluster; drops only on a gate request once armed by
    // the wait read and with a raised indicator, set high again on release or a low indicator
    always_comb begin
        armed_next = armed_reg;
        permit_next = permit_reg;
        if (!cluster_mode_param) begin
            armed_next = 1'b0;
            permit_next = 1'b0; // [R11]
        end else begin
            if (elw_read_seen) begin
                armed_next = 1'b1;
            end
            if (!link.core_sleep) begin
                permit_next = 1'b1; // [R15]
            end else if (release_req) begin
                permit_next = 1'h1; // [R14]
                // A fresh wait read in the same cycle outlives the release
                armed_next = elw_read_seen;
            end else if (gate_req && (armed_reg || elw_read_seen)) begin
                permit_next = 1'b0; // [R14]
            end
        end
        // Debug request and bus answers toward the core are masked while gated off; fetch go is not
        bus_next = {debug_req_in, instr_gnt_in, instr_rvalid_in,
            data_gnt_in, data_rvalid_in};
        if (cluster_mode_param && !permit_next) begin
            bus_next = 5'h00; // [R16]
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            permit_reg <= cluster_mode_param ? `CSG_PERMIT_CLUSTER_RST :
                `CSG_PERMIT_RST; // [R11] [R15]
            armed_reg <= `CSG_ARMED_RST;
            irq_reg <= '0;
            bus_reg <= `CSG_BUS_RST;
            ext_reg <= `CSG_EXT_EN_RST;
        end else if (ce) begin
            permit_reg <= permit_next;
            armed_reg <= armed_next;
            irq_reg <= (cluster_mode_param && !permit_next) ?
                '0 : irq_in; // [R16]
            bus_reg <= bus_next;
            // External gating allowed only in wfi sleep
            ext_reg <= cluster_mode_param | ~link.core_sleep; // [R7] [R9]
        end
    end

    assign link.fetch_go = fetch_go_in;
    assign link.cluster_clk_permit = permit_reg;
    assign link.irq = irq_reg;
    assign link.debug_req = bus_reg[4];
    assign link.instr_gnt = bus_reg[3];
    assign link.instr_rvalid = bus_reg[2];
    assign link.data_gnt = bus_reg[1];
    assign link.data_rvalid = bus_reg[0];
    assign ext_clk_en = ext_reg;

endmodule

//--- rtl/csg_if.sv
/*
 * Link between the core sleep controller and the logic around it.
 * Assumes both ends share clk; the testbench joins them.
 */
`timescale 1ns/1ps

interface csg_if #(
    parameter int NUM_IRQ = 32
) (
    input wire logic clk
);
    // Start and sleep handshake
    logic fetch_go;
    logic cluster_clk_permit;
    logic core_sleep;
    // Wake sources and bus answers, forced low in cluster mode while permit is low
    logic [NUM_IRQ-1:0] irq;
    logic debug_req;
    logic instr_gnt;
    logic instr_rvalid;
    logic data_gnt;
    logic data_rvalid;

    modport dev (
        input fetch_go, cluster_clk_permit, irq, debug_req,
        input instr_gnt, instr_rvalid, data_gnt, data_rvalid,
        output core_sleep
    );

    modport host (
        output fetch_go, cluster_clk_permit, irq, debug_req,
        output instr_gnt, instr_rvalid, data_gnt, data_rvalid,
        input core_sleep
    );
endinterface

//--- rtl/csg_pkg.sv
/*
 * Types used by the sleep controller; its surrounding logic uses none of them.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package csg_pkg;

    // Reason the core is currently asleep
    typedef enum logic [1:0] {
        CSG_AWAKE,
        CSG_WFI_SLEEP,
        CSG_ELW_SLEEP
    } csg_sleep_e;

endpackage

//--- rtl/csg_sleep_ctrl.sv
/*
 * Core sleep controller: owns the only gate on the raw core clock,
 * tracks start-up, sleep through wait-for-interrupt or
 * event-load-wait, and gates the floating-point unit alongside.
 * Assumes all link inputs come from logic on clk (no synchronisers)
 * and that every other core module runs on clk_gated.
 */
`timescale 1ns/1ps
`include "csg_defines.svh"

// Notes on behaviour
// R1: Raw clock used only here; others gated
// R2: Reset holds clock off, sleep low
// R3: Clock off until fetch go first seen
// R4: Fetch go ignored after first assertion
// R5: Wfi sleeps regardless of global enables
// R6: Wfi is nop under debug or cluster
// R7: Wfi sleep raises indicator, gates clock
// R8: Wake on local interrupt, debug request, mode
// R9: Wake clears indicator and ungates clock
// R10: Present wake condition blocks wfi sleep
// R11: Permit tied low outside cluster mode
// R12: Cluster sleep lets permit drive gate
// R13: Event-load-wait sleeps only while load waits
// R14: Permit drops only after wait read, sleep
// R15: Permit high whenever sleep indicator low; outside cluster mode the code ties it low
// R16: In cluster mode, permit low forces wake and bus inputs low
// R17: Floating-point gate enable is inverted sleep; the code also holds it low until fetch go is first seen
// R18: Latch-based gate, enable from synchronous state
module csg_sleep_ctrl #(
    parameter int NUM_IRQ = `CSG_DEFAULT_IRQS,
    parameter bit cluster_mode_param = 1'b0
) (
    // Raw clock, reset, clock enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Link to the surrounding logic
    csg_if.dev link,
    // Core pipeline status
    input wire logic wfi_exec,
    input wire logic event_load_wait_insn,
    input wire logic [NUM_IRQ-1:0] irq_local_en,
    input wire logic debug_pending,
    input wire logic debug_mode,
    input wire logic single_step,
    input wire logic trigger_match,
    // Clocks and status toward the core and floating-point unit
    output logic clk_gated,
    output logic fpu_clk_gated,
    output logic fpu_clk_en,
    output logic fetch_started,
    output logic wake_seen
);

    // Refuse configurations the logic cannot serve, at elaboration
    generate
        if (NUM_IRQ < 1) begin : g_bad_irq
            $error("csg_sleep_ctrl: NUM_IRQ must be at least 1");
        end
    endgenerate

    logic fetch_reg;
    logic fetch_next;
    csg_pkg::csg_sleep_e state_reg;
    csg_pkg::csg_sleep_e state_next;
    logic sleep_reg;
    logic sleep_next;
    logic fpu_en_reg;
    logic fpu_en_next;
    logic wake_reg;
    logic wake_next;
    logic dbg_block;
    logic wake_cond;
    logic elw_waiting;
    logic gate_en;
    logic fpu_gate_en;
    logic [1:0] gate_en_vec;
    logic gate_lat [2];
    logic [1:0] gated_vec;

    // Asleep in either flavour; shared by indicator and wake pulse
    function automatic logic is_asleep(input csg_pkg::csg_sleep_e st);
        is_asleep = (st != csg_pkg::CSG_AWAKE);
    endfunction

    // Any debug activity keeps the core awake
    assign dbg_block = link.debug_req | debug_pending | debug_mode |
        single_step | trigger_match; // [R6] [R13]

    // Global enables are not looked at, only local ones
    assign wake_cond = (|(link.irq & irq_local_en)) |
        debug_pending | link.debug_req | debug_mode; // [R5] [R8]

    // Load still waits while its answer has not come back
    assign elw_waiting = event_load_wait_insn & ~link.data_rvalid;

    // Start-up latch: first fetch go only, then deaf till reset
    always_comb begin
        fetch_next = fetch_reg;
        if (!fetch_reg && link.fetch_go) begin
            fetch_next = 1'b1; // [R3] [R4]
        end
    end

    // Sleep state machine; runs on the raw clock so wake is seen
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            csg_pkg::CSG_AWAKE: begin
                if (!cluster_mode_param && fetch_reg && wfi_exec &&
                    !dbg_block && !wake_cond) begin
                    state_next = csg_pkg::CSG_WFI_SLEEP; // [R6] [R10]
                end else if (cluster_mode_param && fetch_reg &&
                    elw_waiting && !dbg_block) begin
                    state_next = csg_pkg::CSG_ELW_SLEEP; // [R13]
                end
            end
            csg_pkg::CSG_WFI_SLEEP: begin
                if (wake_cond) begin
                    state_next = csg_pkg::CSG_AWAKE; // [R8] [R9]
                end
            end
            csg_pkg::CSG_ELW_SLEEP: begin
                // Leaves once the load completes or debug steps in
                if (!elw_waiting || dbg_block) begin
                    state_next = csg_pkg::CSG_AWAKE; // [R13]
                end
            end
            default: begin
                state_next = csg_pkg::CSG_AWAKE;
            end
        endcase
    end

    // Indicator and floating-point enable follow the next state
    always_comb begin
        sleep_next = is_asleep(state_next); // [R7] [R9]
        fpu_en_next = fetch_next & ~sleep_next; // [R17]
        wake_next = (state_reg == csg_pkg::CSG_WFI_SLEEP) &&
            !is_asleep(state_next);
    end

    // Start-up register; only a reset can re-arm the fetch go
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fetch_reg <= `CSG_FETCH_RST; // [R2]
        end else if (ce) begin
            fetch_reg <= fetch_next; // [R4]
        end
    end

    // Synchronous reset clears the sleep state; ce freezes it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= csg_pkg::CSG_AWAKE;
            sleep_reg <= `CSG_SLEEP_RST; // [R2]
            fpu_en_reg <= `CSG_FPU_EN_RST;
            wake_reg <= `CSG_WAKE_RST;
        end else if (ce) begin
            state_reg <= state_next;
            sleep_reg <= sleep_next;
            fpu_en_reg <= fpu_en_next;
            wake_reg <= wake_next;
        end
    end

    // Gate enable: off in reset and before start, off in wfi
    // sleep; in cluster sleep the permit passes straight through.
    // Permit is used only in cluster mode, so a tied input is moot.
    always_comb begin
        gate_en = nrst & fetch_reg; // [R2] [R3]
        if (sleep_reg) begin
            if (cluster_mode_param) begin
                gate_en = gate_en & link.cluster_clk_permit; // [R12]
            end else begin
                gate_en = 1'b0; // [R7] [R11]
            end
        end
        fpu_gate_en = nrst & fpu_en_reg; // [R17]
    end

    // One latch-based cell per clock: the latch opens while clk is
    // low, so a new enable settles under a low clock and the gated
    // clock cannot glitch; bit 0 is the core, bit 1 the FPU
    assign gate_en_vec = {fpu_gate_en, gate_en};
    generate
        for (genvar g = 0; g < 2; g++) begin : g_gate
            always_latch begin
                if (!clk) begin
                    gate_lat[g] = gate_en_vec[g]; // [R18]
                end
            end
            assign gated_vec[g] = clk & gate_lat[g];
        end
    endgenerate

    // Raw clock leaves this module only through these gates
    assign clk_gated = gated_vec[0]; // [R1] [R18]
    assign fpu_clk_gated = gated_vec[1]; // [R17]

    // Registered status toward the core and the link
    assign link.core_sleep = sleep_reg; // [R7]
    assign fpu_clk_en = fpu_en_reg; // [R17]
    assign fetch_started = fetch_reg;
    assign wake_seen = wake_reg;

endmodule
